// [logic/mds_params.svh]
/*
  Constants for the multisite designator status block: field positions
  within the special designator, selector codes and
  status codes.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef MDS_PARAMS_SVH
`define MDS_PARAMS_SVH

`define MDS_SEL_MULTISITE   3'h1
`define MDS_SEL_SUBCODE     3'h7

// Special designator bit 17 is word bit 15, bit 32 is word bit 0.
`define MDS_SD_SITE_HI      15
`define MDS_SD_SITE_LO      12
`define MDS_SD_MSGB_HI      11
`define MDS_SD_MSGB_LO      10
`define MDS_SD_LONG_HI      9
`define MDS_SD_LONG_LO      7
`define MDS_SD_SUB_HI       11
`define MDS_SD_SUB_LO       8
`define MDS_SD_LOCKOUT      6
`define MDS_SD_STATUS_HI    5
`define MDS_SD_STATUS_LO    4
`define MDS_SD_TAG_HI       3
`define MDS_SD_TAG_LO       0

`define MDS_RT_NONE         2'h0
`define MDS_RT_SHORT        2'h1
`define MDS_RT_UP_LONG      2'h2
`define MDS_RT_DN_LONG      2'h3

`define MDS_SITE_ZERO       4'h0
`define MDS_SUB_ZERO        4'h0
`define MDS_LONG_ZERO       3'h0
`define MDS_MSGB_ZERO       2'h0
`define MDS_WORD_ZERO       6'h00

`define MDS_FMT_SURV_ALT    5'h04
`define MDS_FMT_SURV_ID     5'h05
`define MDS_FMT_COMM_ALT    5'h14
`define MDS_FMT_COMM_ID     5'h15

`endif

// [logic/mds_pkg.sv]
/*
  Types of the multisite designator status block.
  Assumes mds_params.svh is on the include path.
*/
`include "mds_params.svh"

package mds_pkg;

  // Decoded special designator fields.
  typedef struct packed {
    logic       valid;
    logic [3:0] site_ident;
    logic [1:0] multisite_msgb_ctl;
    logic [2:0] multisite_long_msg_ctl;
    logic       multisite_lockout;
    logic [1:0] resv_status_request;
    logic [3:0] reply_source_sub;
    logic [3:0] link_tag;
  } mds_decode_t;

  // One reservation: active flag and owning site.
  typedef struct packed {
    logic       active;
    logic [3:0] owner;
  } mds_resv_t;

  // Utility word: site in its upper bits, type in its lower bits.
  typedef struct packed {
    logic [3:0] site_ident;
    logic [1:0] resv_type;
  } mds_utility_word_t;

endpackage

// [logic/mds_decode.sv]
/*
  Splits a special designator into its subfields for selector codes 1 and 7.
  Assumes the selector and designator are held stable by the caller.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mds_params.svh"

module mds_decode (
  input  wire logic [2:0]          designator_selector,
  input  wire logic [15:0]         special_designator,
  output wire mds_pkg::mds_decode_t fields
);
  import mds_pkg::*;

  wire logic sel_multi;
  wire logic sel_sub;

  assign sel_multi = designator_selector == `MDS_SEL_MULTISITE;
  assign sel_sub   = designator_selector == `MDS_SEL_SUBCODE;

  assign fields.valid = sel_multi | sel_sub;
  assign fields.site_ident = fields.valid ?
    special_designator[`MDS_SD_SITE_HI:`MDS_SD_SITE_LO] : `MDS_SITE_ZERO;
  assign fields.multisite_msgb_ctl = sel_multi ?
    special_designator[`MDS_SD_MSGB_HI:`MDS_SD_MSGB_LO] : `MDS_MSGB_ZERO;
  assign fields.multisite_long_msg_ctl = sel_multi ?
    special_designator[`MDS_SD_LONG_HI:`MDS_SD_LONG_LO] : `MDS_LONG_ZERO;
  assign fields.resv_status_request = sel_multi ?
    special_designator[`MDS_SD_STATUS_HI:`MDS_SD_STATUS_LO] : `MDS_RT_NONE;
  assign fields.reply_source_sub = sel_sub ?
    special_designator[`MDS_SD_SUB_HI:`MDS_SD_SUB_LO] : `MDS_SUB_ZERO;
  assign fields.multisite_lockout = fields.valid &
    special_designator[`MDS_SD_LOCKOUT];
  assign fields.link_tag = fields.valid ?
    special_designator[`MDS_SD_TAG_HI:`MDS_SD_TAG_LO] : `MDS_SITE_ZERO;

endmodule
`default_nettype wire

// [logic/mds_status.sv]
/*
  Multisite designator status: decodes an uplink special designator on
  each accepted interrogation and builds the six-bit utility word of the
  reply, latched when reply assembly begins.
  Assumes interrogations arrive as single-cycle strobes synchronous to clk,
  and that reservation state comes from external reservation machines.
*/
// Behaviour
// - Selector 1: site, short ctl, long ctl, lockout, status request, tag.
// - Selector 7: site, source subcode, lockout, tag; ignore bits 25, 27-28.
// - Six-bit utility word goes into replies of formats 4, 5, 20, 21.
// - Utility word upper four bits carry the reserving site identity.
// - Lower two bits: 0 none, 1 short, 2 uplink long, 3 downlink long.
// - Selector 1 with nonzero status request picks the reported reservation.
// - Otherwise report short reservation if active, else downlink long.
// - No request and no short or downlink long reservation gives zero.
// - Status codes: 0 none, 1 short, 2 uplink long, 3 downlink long.
// - Lockout bit 1 starts lockout for the site; 0 leaves it unchanged.
`timescale 1ns/100ps
`default_nettype none
`include "mds_params.svh"

module mds_status (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                clk_en,
  input  wire logic                interrogation_valid,
  input  wire logic [4:0]          uplink_format_code,
  input  wire logic [2:0]          designator_selector,
  input  wire logic [15:0]         special_designator,
  input  wire mds_pkg::mds_resv_t  short_resv,
  input  wire mds_pkg::mds_resv_t  up_long_resv,
  input  wire mds_pkg::mds_resv_t  dn_long_resv,
  input  wire logic                reply_start,
  input  wire logic [4:0]          reply_format,
  output mds_pkg::mds_utility_word_t utility_word,
  output logic                     utility_word_valid,
  output logic                     lockout_start,
  output logic [3:0]               lockout_site,
  output logic [3:0]               reply_source_sub,
  output logic [3:0]               link_tag,
  output logic                     link_tag_valid
);
  import mds_pkg::*;

  mds_decode_t       dec;
  mds_decode_t       fields_q;
  mds_decode_t       fields_d;
  mds_utility_word_t word_d;
  mds_utility_word_t word_q;
  logic              word_valid_q;
  logic              lock_q;
  logic [3:0]        lock_site_q;
  logic [3:0]        sub_q;
  logic [3:0]        tag_q;
  logic              tag_valid_q;

  wire logic         surv_fmt;
  wire logic         reply_fmt_ok;
  wire logic         take;
  wire logic         latch;

  function automatic logic fmt_carries_word(input logic [4:0] f);
    fmt_carries_word = (f == `MDS_FMT_SURV_ALT) | (f == `MDS_FMT_SURV_ID) |
                       (f == `MDS_FMT_COMM_ALT) | (f == `MDS_FMT_COMM_ID);
  endfunction

  function automatic mds_utility_word_t pack_word(input mds_resv_t r,
                                                  input logic [1:0] t);
    pack_word.site_ident = r.active ? r.owner : `MDS_SITE_ZERO;
    pack_word.resv_type  = r.active ? t : `MDS_RT_NONE;
  endfunction

  mds_decode u_decode (
    .designator_selector (designator_selector),
    .special_designator  (special_designator),
    .fields              (dec)
  );

  assign surv_fmt     = fmt_carries_word(uplink_format_code);
  assign reply_fmt_ok = fmt_carries_word(reply_format);
  assign take  = clk_en & interrogation_valid & surv_fmt;
  assign latch = clk_en & reply_start & reply_fmt_ok;
  assign fields_d = take ? dec : fields_q;

  // Requested status first, then short, then downlink long, else zero.
  always_comb begin
    word_d = {`MDS_SITE_ZERO, `MDS_RT_NONE};
    if (fields_q.valid &&
        fields_q.resv_status_request != `MDS_RT_NONE) begin
      unique case (fields_q.resv_status_request)
        `MDS_RT_SHORT:   word_d = pack_word(short_resv, `MDS_RT_SHORT);
        `MDS_RT_UP_LONG: word_d = pack_word(up_long_resv, `MDS_RT_UP_LONG);
        `MDS_RT_DN_LONG: word_d = pack_word(dn_long_resv, `MDS_RT_DN_LONG);
        default:         word_d = {`MDS_SITE_ZERO, `MDS_RT_NONE};
      endcase
    end else if (short_resv.active) begin
      word_d = pack_word(short_resv, `MDS_RT_SHORT);
    end else if (dn_long_resv.active) begin
      word_d = pack_word(dn_long_resv, `MDS_RT_DN_LONG);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fields_q <= '0;
    end else begin
      fields_q <= fields_d;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      word_q       <= {`MDS_SITE_ZERO, `MDS_RT_NONE};
      word_valid_q <= 1'b0;
    end else if (clk_en) begin
      word_valid_q <= latch;
      if (latch) begin
        word_q <= word_d;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_q      <= 1'b0;
      lock_site_q <= `MDS_SITE_ZERO;
      sub_q       <= `MDS_SUB_ZERO;
      tag_q       <= `MDS_SITE_ZERO;
      tag_valid_q <= 1'b0;
    end else if (clk_en) begin
      lock_q      <= take & dec.multisite_lockout;
      tag_valid_q <= take & dec.valid;
      if (take & dec.multisite_lockout) begin
        lock_site_q <= dec.site_ident;
      end
      if (take & dec.valid) begin
        sub_q <= dec.reply_source_sub;
        tag_q <= dec.link_tag;
      end
    end
  end

  assign utility_word       = word_q;
  assign utility_word_valid = word_valid_q;
  assign lockout_start      = lock_q;
  assign lockout_site       = lock_site_q;
  assign reply_source_sub   = sub_q;
  assign link_tag           = tag_q;
  assign link_tag_valid     = tag_valid_q;

endmodule
`default_nettype wire

// [sim/mds_status_monitor.sv]
/* Assertions on the ports of the multisite status block.
   Assumes it is bound to mds_status with one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module mds_status_monitor (
  input wire logic                       clk,
  input wire logic                       reset,
  input wire logic                       clk_en,
  input wire logic                       interrogation_valid,
  input wire logic [4:0]                 uplink_format_code,
  input wire logic [2:0]                 designator_selector,
  input wire logic [15:0]                special_designator,
  input wire mds_pkg::mds_resv_t         short_resv,
  input wire mds_pkg::mds_resv_t         up_long_resv,
  input wire logic                       reply_start,
  input wire logic [4:0]                 reply_format,
  input wire mds_pkg::mds_utility_word_t utility_word,
  input wire logic                       utility_word_valid,
  input wire logic                       lockout_start,
  input wire logic [3:0]                 lockout_site,
  input wire logic [3:0]                 reply_source_sub,
  input wire logic [3:0]                 link_tag,
  input wire logic                       link_tag_valid
);
  import mds_pkg::*;
  wire logic ti = clk_en && interrogation_valid &&
    uplink_format_code inside {5'h04, 5'h05, 5'h14, 5'h15};
  wire logic tr = clk_en && reply_start &&
    reply_format inside {5'h04, 5'h05, 5'h14, 5'h15};
  wire logic [1:0] rq = special_designator[5:4];
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_req;
    ti && designator_selector == 3'h1 && rq == 2'h2 ##1 !ti
    ##1 tr && up_long_resv.active;
  endsequence
  sequence s_sel7;
    ti && designator_selector == 3'h7 ##1 !ti ##1 tr;
  endsequence
  AST_LOCK: assert property (ti && special_designator[6] &&
    designator_selector inside {3'h1, 3'h7} |=> lockout_start &&
    lockout_site == $past(special_designator[15:12]))
    else $error("lockout not started");
  AST_NOLOCK: assert property (ti && !special_designator[6] |=> !lockout_start)
    else $error("lockout started without cause");
  AST_TAG: assert property (ti && designator_selector == 3'h1 |=>
    link_tag_valid && link_tag == $past(special_designator[3:0]))
    else $error("linking tag wrong");
  AST_SUB: assert property (ti && designator_selector == 3'h7 |=>
    reply_source_sub == $past(special_designator[11:8]))
    else $error("source subcode wrong");
  AST_VALID: assert property (tr |=> utility_word_valid)
    else $error("utility word not latched");
  AST_NOVALID: assert property (clk_en && !tr |=> !utility_word_valid)
    else $error("stray utility word pulse");
  AST_HOLD: assert property (!utility_word_valid |-> $stable(utility_word))
    else $error("utility word moved");
  AST_REQ: assert property (s_req |=>
    utility_word == {$past(up_long_resv.owner), 2'h2})
    else $error("requested status wrong");
  AST_SHORT: assert property (s_sel7 ##0 short_resv.active |=>
    utility_word == {$past(short_resv.owner), 2'h1})
    else $error("short reservation not reported");
endmodule
bind mds_status mds_status_monitor u_mon (.clk(clk), .reset(reset),
  .clk_en(clk_en), .interrogation_valid(interrogation_valid),
  .uplink_format_code(uplink_format_code),
  .designator_selector(designator_selector),
  .special_designator(special_designator), .short_resv(short_resv),
  .up_long_resv(up_long_resv), .reply_start(reply_start),
  .reply_format(reply_format), .utility_word(utility_word),
  .utility_word_valid(utility_word_valid), .lockout_start(lockout_start),
  .lockout_site(lockout_site), .reply_source_sub(reply_source_sub),
  .link_tag(link_tag), .link_tag_valid(link_tag_valid));
`default_nettype wire

// [sim/mds_gnd_model.sv]
/* Ground interrogator model that sends uplink interrogations.
   Assumes the block's clock; fields are scrambled once released. */
`timescale 1ns/100ps
`default_nettype none
module mds_gnd_model (
  input  wire logic        clk,
  output var  logic        interrogation_valid,
  output var  logic [4:0]  uplink_format_code,
  output var  logic [2:0]  designator_selector,
  output var  logic [15:0] special_designator
);
  initial begin
    interrogation_valid = 1'b0;
    uplink_format_code  = 5'h00;
    designator_selector = 3'h0;
    special_designator  = 16'h0000;
  end
  task automatic send(input logic [4:0] f, input logic [2:0] s,
                      input logic [15:0] d);
    @(posedge clk);
    interrogation_valid <= 1'b1;
    uplink_format_code  <= f;
    designator_selector <= s;
    special_designator  <= d;
    @(posedge clk);
    interrogation_valid <= 1'b0;
    designator_selector <= ~s;
    special_designator  <= ~d;
  endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
/* Self-checking bench for the multisite status block.
   Assumes the monitor is bound and the model drives interrogations. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import mds_pkg::*;
  logic clk = 1'b0, reset = 1'b1, reply_start = 1'b0, ls, tv, wv, iv;
  logic ce = 1'b1;
  logic [4:0] fmt, rf = 5'h00;
  logic [2:0] sel;
  logic [15:0] sd;
  logic [3:0] site, sub, tag;
  mds_resv_t sr = 5'h00, ur = 5'h00, dr = 5'h00;
  mds_utility_word_t uw;
  int fail_count = 0, cmp_count = 0;
  always #4 clk = ~clk;
  mds_gnd_model m (.clk(clk), .interrogation_valid(iv),
    .uplink_format_code(fmt), .designator_selector(sel),
    .special_designator(sd));
  mds_status dut (.clk(clk), .reset(reset), .clk_en(ce),
    .interrogation_valid(iv), .uplink_format_code(fmt),
    .designator_selector(sel), .special_designator(sd), .short_resv(sr),
    .up_long_resv(ur), .dn_long_resv(dr), .reply_start(reply_start),
    .reply_format(rf), .utility_word(uw), .utility_word_valid(wv),
    .lockout_start(ls), .lockout_site(site), .reply_source_sub(sub),
    .link_tag(tag), .link_tag_valid(tv));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reply(input logic [4:0] f, input logic [4:0] s, u, d,
                       input logic v, input logic [5:0] e);
    @(posedge clk);
    reply_start <= 1'b1;
    rf <= f;
    sr <= s;
    ur <= u;
    dr <= d;
    @(posedge clk);
    reply_start <= 1'b0;
    #1;
    chk(wv, v);
    if (v) chk(uw, e);
  endtask
  task automatic summarize();
    $display("Checks %0d, errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    m.send(5'h14, 3'h1, 16'h506A);
    #1;
    chk(ls, 1);
    chk(site, 5);
    chk(tag, 4'hA);
    reply(5'h14, 5'h00, 5'h15, 5'h00, 1, 6'h16);
    for (int c = 1; c < 4; c++) begin
      m.send(5'h04, 3'h1, {4'h1, 5'h00, 1'b0, 2'(c), 4'h0});
      #1;
      chk(ls, 0);
      reply(5'h05, 5'h12, 5'h13, 5'h14, 1, {4'(c + 1), 2'(c)});
    end
    m.send(5'h15, 3'h7, 16'h3904);
    #1;
    chk(sub, 4'h9);
    chk(tv, 1);
    reply(5'h15, 5'h16, 5'h17, 5'h18, 1, 6'h19);
    reply(5'h04, 5'h06, 5'h17, 5'h18, 1, 6'h23);
    m.send(5'h04, 3'h3, 16'h506A);
    #1;
    chk(tv, 0);
    reply(5'h14, 5'h00, 5'h17, 5'h00, 1, 6'h00);
    reply(5'h0B, 5'h16, 5'h00, 5'h00, 0, 6'h00);
    @(posedge clk);
    ce <= 1'b0;
    m.send(5'h04, 3'h1, 16'h7060);
    #1;
    chk(ls, 0);
    chk(site, 5);
    @(posedge clk);
    ce <= 1'b1;
    reply(5'h14, 5'h16, 5'h00, 5'h00, 1, 6'h19);
    summarize();
  end
endmodule
`default_nettype wire
